/* File: pkg/eep_regs.vh */
// eep_regs.vh: constants of the serial memory protocol engine.
// assumes inclusion by bare name from design files; definitions only.
`ifndef EEP_REGS_VH
`define EEP_REGS_VH

// core clock
`define EEP_CLK_PERIOD_NS 5
// internal program time, plain default
`define EEP_PROG_TIME_NS 5000000

// select byte layout
`define EEP_SEL_TYPE_HI 7
`define EEP_SEL_TYPE_LO 4
`define EEP_SEL_CHIP_HI 3
`define EEP_SEL_CHIP_LO 1
`define EEP_SEL_DIR_BIT 0
`define EEP_DIR_READ 1'b1

// byte framing
`define EEP_BITS_PER_BYTE 4'h8
`define EEP_PAGE_BYTES 16
`define EEP_PAGE_BITS 4
`define EEP_MAX_ADDR_W 11
`define EEP_MEM_FILL 8'hff

`endif

/* File: verilog/eep_mem.v */
// eep_mem.v: byte array of the serial memory, one write and one read port.
// assumes a single core clock; read data are registered.
`timescale 1ns/10ps
`default_nettype none
`include "eep_regs.vh"

module eep_mem #(
   parameter AW = 11,
   parameter DW = 8
) (
   // clock
   input wire core_clk_in,
   // write port
   input wire we_in,
   input wire [AW-1:0] waddr_in,
   input wire [DW-1:0] wdata_in,
   // read port
   input wire [AW-1:0] raddr_in,
   output reg [DW-1:0] rdata_out
);
   localparam DEPTH = 1 << AW;
   reg [DW-1:0] cells [0:DEPTH-1];
   integer i;

   // delivered erased
   initial begin
      for (i = 0; i < DEPTH; i = i + 1) begin
         cells[i] = `EEP_MEM_FILL;
      end
   end

   always @(posedge core_clk_in) begin
      if (we_in) begin
         cells[waddr_in] <= wdata_in;
      end
      rdata_out <= cells[raddr_in];
   end
endmodule
`default_nettype wire

/* File: verilog/eep_proto.v */
// eep_proto.v: two-wire slave protocol engine of a serial memory.
// assumes open-drain data pin resolved outside, master drives the clock pin.
`timescale 1ns/10ps
`default_nettype none
`include "eep_regs.vh"

// What this block does
// RULE1: start is data falling while clock high; detected before every command.
// RULE2: outside a write cycle, watch for start; ignore everything until one.
// RULE3: stop is data rising while clock high; it ends the exchange.
// RULE4: transmitter releases data after eight bits; receiver pulls low on ninth.
// RULE5: data sampled on clock rise; master changes data only while clock low.
// RULE6: select byte msb first: 4-bit type, 3-bit chip address matched to pins.
// RULE7: larger parts carry address bits 8, 9, 10 instead of select pins.
// RULE8: eighth select bit is direction: one reads, zero writes.
// RULE9: acknowledge on match; on mismatch release data and wait for start.
// RULE10: after write select, next byte is the address, then data follow.
// RULE11: only a stop in slot ten after a data acknowledge starts programming.
// RULE12: during the write cycle both pins are ignored entirely.
// RULE13: protect seen from start to address end refuses the data byte.
// RULE14: a page write takes one to sixteen bytes within one page.
// RULE15: each written byte bumps only the four low address bits.
// RULE16: page data acknowledged unless protect was seen; then nothing changes.
// RULE17: while busy no select is acknowledged; afterwards polling is acknowledged.
// RULE18: reads behave the same whatever the protect level.
// RULE19: random read is dummy write then repeated start and read select.
// RULE20: current read returns byte at counter, then counter increments.
// RULE21: acknowledged reads continue at consecutive addresses, wrapping to zero.
// RULE22: no acknowledge after a read byte ends sending and goes to standby.
// RULE23: with protect high, select and address bytes are still acknowledged.
// RULE24: protect input reads low unless driven high.
// RULE25: pins high, mid, low compare with select bits three, two, one.
// RULE26: write cycle length is a configurable count of core clock cycles.
module eep_proto #(
   parameter SEL_ADDR_BITS = 3,
   parameter [3:0] DEV_TYPE = 4'h5, // arbitrary value
   parameter PROG_CYCLES = `EEP_PROG_TIME_NS / `EEP_CLK_PERIOD_NS
) (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // two-wire bus
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   // straps
   input wire chip_select_pin_low_in,
   input wire chip_select_pin_mid_in,
   input wire chip_select_pin_high_in,
   input wire write_protect_input_in,
   // status
   output reg busy_out
);
   localparam AW = 8 + SEL_ADDR_BITS;
   localparam [10:0] ADDR_MASK = ~(11'h7ff << AW);
   localparam [5:0] PIN_IDLE = 6'h03;

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_SEL = 4'h1;
   localparam [3:0] ST_SEL_ACK = 4'h2;
   localparam [3:0] ST_ADDR = 4'h3;
   localparam [3:0] ST_ADDR_ACK = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_WDATA_ACK = 4'h6;
   localparam [3:0] ST_RDATA = 4'h7;
   localparam [3:0] ST_RACK = 4'h8;
   localparam [3:0] ST_BUSY = 4'h9;

   // pin synchronisers
   wire [5:0] pin_raw;
   wire [5:0] pin_f;
   assign pin_raw = {write_protect_input_in, chip_select_pin_high_in,
      chip_select_pin_mid_in, chip_select_pin_low_in, sda_in, scl_in};

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_sync
         reg [2:0] stage;
         reg filt;
         always @(posedge core_clk_in) begin
            if (!rst_n_in) begin
               stage <= {3{PIN_IDLE[g]}};
               filt <= PIN_IDLE[g];
            end else begin
               stage <= {stage[1:0], pin_raw[g]};
               if (stage[1] == stage[2]) begin
                  filt <= stage[2];
               end
            end
         end
         assign pin_f[g] = filt;
      end
   endgenerate

   wire scl;
   wire sda;
   wire [2:0] cs_pins;
   wire wp_pin;
   assign scl = pin_f[0];
   assign sda = pin_f[1];
   assign cs_pins = pin_f[4:2];
   assign wp_pin = pin_f[5]; // RULE24

   // bus conditions
   reg scl_d;
   reg sda_d;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   assign scl_rise = scl & ~scl_d; // RULE5
   assign scl_fall = ~scl & scl_d;
   assign start_cond = scl & scl_d & sda_d & ~sda; // RULE1
   assign stop_cond = scl & scl_d & ~sda_d & sda; // RULE3

   // engine state
   reg [3:0] state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg [7:0] txreg;
   reg [10:0] addr;
   reg wp_lat;
   reg is_read;
   reg master_ack;
   reg [6:0] wpage;
   reg [15:0] page_mask;
   reg [31:0] busy_cnt;
   reg [4:0] prog_idx;
   reg prog_we_q;
   reg [10:0] prog_addr_q;

   // select match
   wire [2:0] sel_ok;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_cmp
         assign sel_ok[g] = (g < SEL_ADDR_BITS) ||
            (shreg[`EEP_SEL_CHIP_LO + g] == cs_pins[g]); // RULE7 RULE25
      end
   endgenerate
   wire sel_match;
   assign sel_match = (shreg[`EEP_SEL_TYPE_HI:`EEP_SEL_TYPE_LO] == DEV_TYPE) &&
      (&sel_ok); // RULE6
   wire byte_done;
   assign byte_done = scl_fall && (bitcnt == `EEP_BITS_PER_BYTE);
   wire slot_ten_stop;
   assign slot_ten_stop = stop_cond && (state == ST_WDATA) && (bitcnt == 4'h1) &&
      (page_mask != 16'h0000); // RULE11

   // memory ports
   wire [7:0] rdata;
   wire [7:0] pbuf_rdata;
   wire pbuf_we;
   wire prog_we;
   wire [10:0] prog_addr;
   assign pbuf_we = (state == ST_WDATA) && byte_done && !wp_lat; // RULE14 RULE16
   assign prog_we = (state == ST_BUSY) && !prog_idx[4] && page_mask[prog_idx[3:0]];
   assign prog_addr = {wpage, prog_idx[3:0]};

   // page latches, read one cycle ahead of the array write
   eep_mem #(
      .AW(`EEP_PAGE_BITS),
      .DW(8)
   ) u_page (
      .core_clk_in(core_clk_in),
      .we_in(pbuf_we),
      .waddr_in(addr[3:0]),
      .wdata_in(shreg),
      .raddr_in(prog_idx[3:0]),
      .rdata_out(pbuf_rdata)
   );

   eep_mem #(
      .AW(AW),
      .DW(8)
   ) u_mem (
      .core_clk_in(core_clk_in),
      .we_in(prog_we_q),
      .waddr_in(prog_addr_q[AW-1:0]),
      .wdata_in(pbuf_rdata),
      .raddr_in(addr[AW-1:0]),
      .rdata_out(rdata)
   );

   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         txreg <= 8'h00;
         addr <= 11'h000;
         wp_lat <= 1'b0;
         is_read <= 1'b0;
         master_ack <= 1'b0;
         wpage <= 7'h00;
         page_mask <= 16'h0000;
         busy_cnt <= 32'h0;
         prog_idx <= 5'h00;
         prog_we_q <= 1'b0;
         prog_addr_q <= 11'h000;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
         prog_we_q <= prog_we;
         prog_addr_q <= prog_addr;
         if (state == ST_BUSY) begin
            // pins ignored, page copied then program time runs out
            sda_oe_out <= 1'b0; // RULE12
            if (!prog_idx[4]) begin
               prog_idx <= prog_idx + 5'h01;
            end
            if (busy_cnt >= PROG_CYCLES - 1) begin // RULE26
               busy_cnt <= 32'h0;
               busy_out <= 1'b0;
               page_mask <= 16'h0000;
               state <= ST_IDLE; // RULE17
            end else begin
               busy_cnt <= busy_cnt + 32'h1;
            end
         end else if (start_cond) begin
            // also serves as repeated start
            state <= ST_SEL; // RULE2 RULE19
            page_mask <= 16'h0000;
            bitcnt <= 4'h0;
            sda_oe_out <= 1'b0;
            wp_lat <= wp_pin; // RULE13
         end else if (stop_cond) begin
            sda_oe_out <= 1'b0;
            bitcnt <= 4'h0;
            if (slot_ten_stop) begin
               // slot ten right after a data acknowledge
               wpage <= addr[10:4]; // RULE11
               prog_idx <= 5'h00;
               busy_cnt <= 32'h0;
               busy_out <= 1'b1;
               state <= ST_BUSY;
            end else begin
               page_mask <= 16'h0000; // RULE11
               state <= ST_IDLE; // RULE3
            end
         end else begin
            case (state)
               ST_IDLE: begin
                  sda_oe_out <= 1'b0; // RULE2
               end
               ST_SEL, ST_ADDR, ST_WDATA: begin
                  if (state != ST_WDATA) begin
                     wp_lat <= wp_lat | wp_pin; // RULE13
                  end
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda}; // RULE5
                     bitcnt <= bitcnt + 4'h1;
                  end else if (byte_done) begin
                     bitcnt <= 4'h0;
                     if (state == ST_SEL) begin
                        if (sel_match) begin
                           is_read <= (shreg[`EEP_SEL_DIR_BIT] == `EEP_DIR_READ); // RULE8
                           addr <= {shreg[`EEP_SEL_CHIP_HI:`EEP_SEL_CHIP_LO], addr[7:0]}
                              & ADDR_MASK; // RULE7
                           sda_oe_out <= 1'b1; // RULE9 RULE23
                           state <= ST_SEL_ACK;
                        end else begin
                           sda_oe_out <= 1'b0; // RULE9
                           state <= ST_IDLE;
                        end
                     end else if (state == ST_ADDR) begin
                        addr <= {addr[10:8], shreg} & ADDR_MASK; // RULE10
                        sda_oe_out <= 1'b1; // RULE23
                        state <= ST_ADDR_ACK;
                     end else begin
                        if (!wp_lat) begin
                           page_mask[addr[3:0]] <= 1'b1; // RULE14
                           addr <= {addr[10:4], addr[3:0] + 4'h1}; // RULE15
                        end
                        sda_oe_out <= ~wp_lat; // RULE13 RULE16
                        state <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_SEL_ACK: begin
                  wp_lat <= wp_lat | wp_pin; // RULE13
                  if (scl_fall) begin
                     if (is_read) begin
                        // first byte of a read, ignores protect
                        txreg <= {rdata[6:0], 1'b0}; // RULE18 RULE20
                        sda_oe_out <= ~rdata[7];
                        bitcnt <= 4'h0;
                        state <= ST_RDATA;
                     end else begin
                        page_mask <= 16'h0000;
                        sda_oe_out <= 1'b0; // RULE4
                        state <= ST_ADDR; // RULE10
                     end
                  end
               end
               ST_ADDR_ACK, ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     sda_oe_out <= 1'b0; // RULE4
                     bitcnt <= 4'h0;
                     state <= ST_WDATA; // RULE10
                  end
               end
               ST_RDATA: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 4'h1;
                  end else if (byte_done) begin
                     sda_oe_out <= 1'b0; // RULE4
                     addr <= (addr + 11'h001) & ADDR_MASK; // RULE20 RULE21
                     state <= ST_RACK;
                  end else if (scl_fall) begin
                     sda_oe_out <= ~txreg[7];
                     txreg <= {txreg[6:0], 1'b0};
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     master_ack <= ~sda; // RULE22
                  end else if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (master_ack) begin
                        txreg <= {rdata[6:0], 1'b0}; // RULE21
                        sda_oe_out <= ~rdata[7];
                        state <= ST_RDATA;
                     end else begin
                        sda_oe_out <= 1'b0; // RULE22
                        state <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  sda_oe_out <= 1'b0;
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/eep_proto_end.v */
// eep_proto_end.v: holds no logic.
// assumes nothing of its surroundings.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: bench/eep_proto_assertions.sv */
// eep_proto_assertions.sv: port checks of the protocol engine.
// assumes slow bus clock phases, as the bench master makes them.
`timescale 1ns/10ps
`default_nettype none
`include "eep_regs.vh"
module eep_proto_assertions #(
   parameter SEL_ADDR_BITS = 3,
   parameter [3:0] DEV_TYPE = 4'h5, // arbitrary value
   parameter PROG_CYCLES = `EEP_PROG_TIME_NS / `EEP_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   // straps and status
   input wire logic chip_select_pin_low_in,
   input wire logic chip_select_pin_mid_in,
   input wire logic chip_select_pin_high_in,
   input wire logic write_protect_input_in,
   input wire logic busy_out
);
   int bcnt;
   always @(posedge core_clk_in) begin
      if (!rst_n_in || !busy_out) begin
         bcnt <= 0;
      end else begin
         bcnt <= bcnt + 1;
      end
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence start_s;
      scl_in && $fell(sda_in);
   endsequence
   sequence stop_s;
      scl_in && $rose(sda_in);
   endsequence
   sequence drive_s;
      $rose(sda_oe_out);
   endsequence
   sda_zero_a: assert property (sda_out == 1'b0)
      else $error("data output not low");
   drive_time_a: assert property (drive_s |-> !scl_in && !$past(scl_in, 2) && $past(scl_in, 8))
      else $error("drive not just after clock fall");
   high_hold_a: assert property ($rose(scl_in) |=> $stable(sda_oe_out) [*8])
      else $error("drive changed in clock high");
   start_rel_a: assert property (start_s |-> ##[1:8] !sda_oe_out)
      else $error("data held after start");
   stop_rel_a: assert property (stop_s |-> ##[1:8] !sda_oe_out)
      else $error("data held after stop");
   busy_quiet_a: assert property (busy_out |-> !sda_oe_out)
      else $error("drive while busy");
   busy_cause_a: assert property ($rose(busy_out) |-> scl_in && sda_in && $past(scl_in, 4))
      else $error("write cycle without stop");
   busy_len_a: assert property ($fell(busy_out) |-> bcnt == PROG_CYCLES)
      else $error("write cycle length wrong");
endmodule
bind eep_proto eep_proto_assertions #(
   .SEL_ADDR_BITS(SEL_ADDR_BITS), .DEV_TYPE(DEV_TYPE), .PROG_CYCLES(PROG_CYCLES)
) u_eep_proto_assertions (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
   .chip_select_pin_low_in(chip_select_pin_low_in),
   .chip_select_pin_mid_in(chip_select_pin_mid_in),
   .chip_select_pin_high_in(chip_select_pin_high_in),
   .write_protect_input_in(write_protect_input_in)
);
`default_nettype wire

/* File: bench/eep_master.sv */
// eep_master.sv: behavioural two-wire bus master.
// assumes a pull-up on data; driving 1 releases the line.
`timescale 1ns/10ps
`default_nettype none
module eep_master (
   // clock and resolved data wire
   input wire logic clk_in,
   input wire logic sda_in,
   // bus clock and data drive
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // third of a bit, 10 core cycles
   task automatic step(input logic c, input logic d);
      scl_out = c;
      sda_out = d;
      wt(10);
   endtask
   task automatic start();
      step(1'b0, sda_out);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, sda_out);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, sda_out);
      step(1'b0, b);
      step(1'b1, b);
      r = sda_in;
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
         output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(mack, ack);
   endtask
endmodule
`default_nettype wire

/* File: bench/eep_proto_bench.sv */
// eep_proto_bench.sv: directed scenarios for the protocol engine.
// assumes the master model on the bus and the checker bound in.
`timescale 1ns/10ps
`default_nettype none
module eep_proto_bench;
   localparam logic [3:0] DT = 4'h6; // arbitrary type code
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic pin_lo = 1'b1;
   logic pin_mid = 1'b0;
   logic pin_hi = 1'b1;
   logic [7:0] q;
   logic a;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   wire logic scl, m_sda, oe, sd_o, busy, sda;
   assign sda = m_sda & (~oe | sd_o);
   initial begin
      forever #2.5 clk = ~clk;
   end
   eep_proto #(.SEL_ADDR_BITS(1), .DEV_TYPE(DT), .PROG_CYCLES(400)) u_eep_proto (
      .core_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sd_o),
      .sda_oe_out(oe), .chip_select_pin_low_in(pin_lo), .chip_select_pin_mid_in(pin_mid),
      .chip_select_pin_high_in(pin_hi), .write_protect_input_in(wp), .busy_out(busy));
   eep_master u_eep_master (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] sel(input logic rw, input logic a8);
      return {DT, 2'b10, a8, rw};
   endfunction
   task automatic x(input logic [7:0] d, input logic m);
      u_eep_master.xfer(d, m, q, a);
   endtask
   task automatic xa(input string nm, input logic [7:0] d, input logic e);
      x(d, 1'b1);
      chk(nm, {7'h0, e}, {7'h0, a});
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 600 && busy !== 1'b0; i++)
         u_eep_master.wt(1);
      chk("busy end", 8'h0, {7'h0, busy});
   endtask
   task automatic rd_at(input logic a8, input logic [7:0] ad, input logic [7:0] e);
      u_eep_master.start();
      xa("dsel", sel(1'b0, a8), 1'b0);
      xa("daddr", ad, 1'b0);
      u_eep_master.start();
      xa("rsel", sel(1'b1, a8), 1'b0);
      x(8'hff, 1'b1);
      chk("rd data", e, q);
      u_eep_master.stop();
   endtask
   task automatic t_byte_write();
      u_eep_master.start();
      xa("wsel", sel(1'b0, 1'b0), 1'b0);
      xa("waddr", 8'h23, 1'b0);
      xa("wdata", 8'h5a, 1'b0);
      u_eep_master.stop();
      chk("busy", 8'h1, {7'h0, busy});
      u_eep_master.start();
      xa("poll busy", sel(1'b0, 1'b0), 1'b1);
      wait_idle();
      u_eep_master.start();
      xa("poll done", sel(1'b0, 1'b0), 1'b0);
      u_eep_master.stop();
      chk("no prog", 8'h0, {7'h0, busy});
      rd_at(1'b0, 8'h23, 8'h5a);
   endtask
   task automatic t_protect();
      wp = 1'b1;
      u_eep_master.start();
      xa("psel", sel(1'b0, 1'b0), 1'b0);
      xa("paddr", 8'h23, 1'b0);
      wp = 1'b0;
      xa("pdata", 8'ha5, 1'b1);
      u_eep_master.stop();
      chk("no prog", 8'h0, {7'h0, busy});
      wp = 1'b1;
      rd_at(1'b0, 8'h23, 8'h5a);
      wp = 1'b0;
   endtask
   task automatic t_page();
      u_eep_master.start();
      xa("gsel", sel(1'b0, 1'b1), 1'b0);
      xa("gaddr", 8'h3e, 1'b0);
      for (int i = 0; i < 5; i++)
         xa("gdata", 8'hc0 + i[7:0], 1'b0);
      u_eep_master.stop();
      wait_idle();
      rd_at(1'b1, 8'h3e, 8'hc0);
      rd_at(1'b1, 8'h30, 8'hc2);
      rd_at(1'b1, 8'h2f, 8'hff);
      u_eep_master.start();
      xa("csel", sel(1'b1, 1'b1), 1'b0);
      x(8'hff, 1'b0);
      chk("cur rd", 8'hc2, q);
      x(8'hff, 1'b1);
      chk("seq rd", 8'hc3, q);
      x(8'hff, 1'b1);
      chk("silent", 8'hff, q);
      u_eep_master.stop();
   endtask
   task automatic t_select();
      u_eep_master.start();
      xa("chip miss", {DT, 4'h0}, 1'b1);
      xa("no start", 8'h23, 1'b1);
      u_eep_master.start();
      xa("type miss", {~DT, 4'h8}, 1'b1);
      pin_mid = 1'b1;
      pin_lo = 1'b0;
      u_eep_master.start();
      xa("mid pin", {DT, 4'he}, 1'b0);
      u_eep_master.stop();
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      u_eep_master.wt(8);
      t_byte_write();
      t_protect();
      t_page();
      t_select();
      report_and_stop();
   end
endmodule
`default_nettype wire
